// ### logic/fieldbus_error_reaction_consts.svh
// Summary of operation
// - Partial cut: light class, bus, remote errors
// - Partial cut sets general and bus flags
// - None found: bus error, general, bus flags
// - Two of three-plus lost: same as none
// - I/O fault: remote error, general, class-four
// - Shared address flagged only when inputs differ
// - Same-type shared address otherwise causes nothing
`ifndef FIELDBUS_ERROR_REACTION_CONSTS_SVH
`define FIELDBUS_ERROR_REACTION_CONSTS_SVH
`define FER_NUM_UNITS      8
`define FER_LOST_MANY      2
`define FER_MIN_UNITS_MANY 3
`endif

// ### logic/fieldbus_error_reaction_pkg.sv
package fieldbus_error_reaction_pkg;
    typedef enum logic [1:0] {
        bus_ok_type_v,
        bus_partial_type_v,
        bus_none_type_v
    } bus_state_type;
endpackage : fieldbus_error_reaction_pkg

// ### logic/unit_count.sv
`timescale 1ns/1ns
`default_nettype none
module unit_count #(
    parameter int N = 8
) (
    input  wire logic [N-1:0]         bits,  // Bits to count
    output logic [$clog2(N+1)-1:0]    count  // Number of set bits
);
    always_comb begin
        count = '0;
        for (int i = 0; i < N; i++) begin
            count = count + {{($clog2(N+1)-1){1'b0}}, bits[i]};
        end
    end
endmodule : unit_count
`default_nettype wire

// ### logic/fieldbus_error_reaction.sv
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_error_reaction_consts.svh"
module fieldbus_error_reaction
    import fieldbus_error_reaction_pkg::*;
#(
    parameter int N = `FER_NUM_UNITS
) (
    input  wire logic         sys_clk,                       // 125 MHz clock
    input  wire logic         rst_b,                         // Async reset, active low
    input  wire logic [N-1:0] unit_configured,               // Units expected on bus
    input  wire logic [N-1:0] unit_responding,               // Units answering (pin level)
    input  wire logic [N-1:0] unit_io_fault,                 // I/O fault per unit (pin level)
    input  wire logic [N-1:0] dup_addr_same_type,            // Shared address, same type
    input  wire logic [N-1:0] dup_inputs_differ,             // Shared-address inputs differ
    input  wire logic         flags_clear,                   // Software clear pulse
    output logic              light_error_class,             // Light class shown
    output logic              warning_error_class,           // Warning class shown
    output logic              bus_error_indication,          // Bus error shown
    output logic              remote_unit_error_indication,  // Remote unit error shown
    output logic              general_error_flag,            // Sticky general flag
    output logic              bus_error_flag,                // Sticky bus flag
    output logic              remote_io_error_flag           // Sticky class-four flag
);
    import fieldbus_error_reaction_pkg::*;

    localparam int CW = $clog2(N+1);

    // Two-stage synchronisers for pin inputs
    logic [N-1:0] resp_s1_r, resp_r, fault_s1_r, fault_r, same_s1_r, same_r;
    logic [N-1:0] diff_s1_r, diff_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            resp_s1_r  <= '0;
            resp_r     <= '0;
            fault_s1_r <= '0;
            fault_r    <= '0;
            same_s1_r  <= '0;
            same_r     <= '0;
            diff_s1_r  <= '0;
            diff_r     <= '0;
        end else begin
            resp_s1_r  <= unit_responding;
            resp_r     <= resp_s1_r;
            fault_s1_r <= unit_io_fault;
            fault_r    <= fault_s1_r;
            same_s1_r  <= dup_addr_same_type;
            same_r     <= same_s1_r;
            diff_s1_r  <= dup_inputs_differ;
            diff_r     <= diff_s1_r;
        end
    end

    // shared address only counts once inputs differ
    logic [N-1:0] dup_err, present, lost;
    assign dup_err = same_r & diff_r & unit_configured;
    assign present = resp_r & unit_configured & ~dup_err;
    assign lost    = unit_configured & ~present;

    logic [CW-1:0] n_cfg, n_present, n_lost;
    unit_count #(.N(N)) u_cfg  (.bits(unit_configured), .count(n_cfg));
    unit_count #(.N(N)) u_pres (.bits(present),         .count(n_present));
    unit_count #(.N(N)) u_lost (.bits(lost),            .count(n_lost));

    // no false none-found at start-up
    // Synchronisers hold reset zeros for two edges; they would read as all units gone
    logic [1:0] warm_r;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            warm_r <= 2'b00;
        else
            warm_r <= {warm_r[0], 1'b1};
    end
    logic live;
    assign live = warm_r[1];

    // none found, or two lost of three-plus
    bus_state_type bus_nxt;
    always_comb begin
        bus_nxt = bus_ok_type_v;
        if (!live)
            bus_nxt = bus_ok_type_v;
        else if (n_cfg != '0 && n_present == '0)
            bus_nxt = bus_none_type_v;
        else if (n_cfg >= CW'(`FER_MIN_UNITS_MANY) && n_lost == CW'(`FER_LOST_MANY))
            bus_nxt = bus_none_type_v;
        else if (n_lost != '0)
            bus_nxt = bus_partial_type_v;
    end

    logic io_err;
    assign io_err = |(fault_r & present);

    // partial: light class plus bus and remote
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            light_error_class            <= 1'b0;
            bus_error_indication         <= 1'b0;
            remote_unit_error_indication <= 1'b0;
            warning_error_class          <= 1'b0;
        end else begin
            light_error_class            <= (bus_nxt == bus_partial_type_v);
            bus_error_indication         <= (bus_nxt != bus_ok_type_v);
            // remote error on fault or duplicate
            remote_unit_error_indication <= (bus_nxt == bus_partial_type_v) || io_err
                                            || (|dup_err);
            warning_error_class          <= io_err;
        end
    end

    logic set_bus, set_io;
    assign set_bus = (bus_nxt != bus_ok_type_v) || (|dup_err);
    assign set_io  = io_err;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_error_flag       <= 1'b0;
            remote_io_error_flag <= 1'b0;
        end else begin
            bus_error_flag       <= set_bus | (bus_error_flag & ~flags_clear);
            remote_io_error_flag <= set_io | (remote_io_error_flag & ~flags_clear);
        end
    end

    // general flag tracks any specific flag
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            general_error_flag <= 1'b0;
        else
            general_error_flag <= set_bus | set_io | (general_error_flag & ~flags_clear);
    end

    // Assertions
    general_follows_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(bus_error_flag) || $rose(remote_io_error_flag) |-> general_error_flag)
        else $error("general flag missing");
    flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(general_error_flag) && !$past(flags_clear) |-> general_error_flag)
        else $error("general flag lost");
    partial_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        light_error_class |-> bus_error_indication && remote_unit_error_indication)
        else $error("partial indications incomplete");
    partial_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        light_error_class |-> bus_error_flag && general_error_flag)
        else $error("partial flags missing");
    none_found_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_nxt == bus_none_type_v |=> bus_error_indication && !light_error_class
        && bus_error_flag)
        else $error("none-found reaction wrong");
    io_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        io_err |=> remote_unit_error_indication && remote_io_error_flag && general_error_flag)
        else $error("io fault reaction wrong");
    dup_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (|dup_err) |=> remote_unit_error_indication && bus_error_flag)
        else $error("duplicate reaction wrong");
    warn_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        warning_error_class |-> remote_io_error_flag)
        else $error("warning without flag");

    // Single-cycle clear: quiet request, then all flags low on the next edge
    sequence clear_quiet_s;
        flags_clear && !set_bus && !set_io;
    endsequence
    sequence flags_low_s;
        !general_error_flag && !bus_error_flag && !remote_io_error_flag;
    endsequence
    sequence cut_seen_s;
        bus_nxt == bus_partial_type_v;
    endsequence
    sequence cut_shown_s;
        light_error_class && bus_error_indication && remote_unit_error_indication;
    endsequence

    clear_works_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clear_quiet_s |=> flags_low_s)
        else $error("flags not cleared");

    // A clear that meets a set must lose
    set_wins_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        flags_clear && set_bus |=> bus_error_flag && general_error_flag)
        else $error("clear beat a set");

    general_cover_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_error_flag || remote_io_error_flag |-> general_error_flag)
        else $error("general flag below a specific flag");

    partial_react_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cut_seen_s |=> cut_shown_s)
        else $error("partial cut not shown");

    partial_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cut_seen_s |=> bus_error_flag && general_error_flag)
        else $error("partial cut flags missing");

    bus_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_error_flag && !flags_clear |=> bus_error_flag)
        else $error("bus flag dropped");

    none_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        bus_nxt == bus_none_type_v && !io_err && !(|dup_err)
        |=> !light_error_class && !remote_unit_error_indication)
        else $error("none-found shows extra classes");

    // Start-up zeros in the synchronisers must not read as none found
    warm_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !live |=> !bus_error_indication && !bus_error_flag)
        else $error("bus error before pins settled");

    two_lost_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        n_cfg >= CW'(`FER_MIN_UNITS_MANY) && n_lost == CW'(`FER_LOST_MANY) && live
        |=> bus_error_indication && !light_error_class && bus_error_flag)
        else $error("two-lost reaction wrong");

    io_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        remote_io_error_flag && !flags_clear |=> remote_io_error_flag)
        else $error("class-four flag dropped");

    warn_follows_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        io_err |=> warning_error_class)
        else $error("warning class missing");

    dup_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (|(same_r & ~diff_r)) && !(|dup_err) && !io_err && bus_nxt == bus_ok_type_v
        |=> !remote_unit_error_indication && !bus_error_indication)
        else $error("agreeing duplicates caused a reaction");
endmodule : fieldbus_error_reaction
`default_nettype wire

// ### verif/remote_units.sv
`timescale 1ns/1ns
`default_nettype none
module remote_units #(
    parameter int N = 8
) (
    input  wire logic         sys_clk,          // Bus clock
    input  wire logic [N-1:0] link_up,          // Unit still reaches the master
    input  wire logic [N-1:0] io_short,         // Short at the unit's I/O
    output logic      [N-1:0] unit_responding,  // Answer seen by the master
    output logic      [N-1:0] unit_io_fault,    // Fault report to the master
    output logic      [N-1:0] unit_out          // Unit output level
);
    always_ff @(posedge sys_clk) begin
        unit_responding <= link_up;
        unit_out        <= link_up & ~io_short;
    end
    always_ff @(posedge sys_clk) begin
        unit_io_fault <= io_short & link_up;
    end
endmodule : remote_units
`default_nettype wire

// ### verif/fieldbus_error_reaction_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %b exp %b", $time, g, e); end end
module fieldbus_error_reaction_tb;
    logic       sys_clk     = 1'b0;
    logic       rst_b       = 1'b0;
    logic [7:0] link_up     = 8'h0F;
    logic [7:0] io_short    = 8'h00;
    logic [7:0] dup_same    = 8'h00;
    logic [7:0] dup_diff    = 8'h00;
    logic       flags_clear = 1'b0;
    logic [7:0] cfg         = 8'h0F;
    logic [7:0] resp, iof, outs;
    wire  [5:0] obs;
    logic       warn;
    int         bad_count   = 0;
    int         num_checks  = 0;
    always #4 sys_clk = ~sys_clk;
    remote_units #(.N(8)) far (.sys_clk(sys_clk), .link_up(link_up), .io_short(io_short),
        .unit_responding(resp), .unit_io_fault(iof), .unit_out(outs));
    fieldbus_error_reaction #(.N(8)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .unit_configured(cfg), .unit_responding(resp), .unit_io_fault(iof),
        .dup_addr_same_type(dup_same), .dup_inputs_differ(dup_diff),
        .flags_clear(flags_clear), .light_error_class(obs[5]), .warning_error_class(warn),
        .bus_error_indication(obs[4]), .remote_unit_error_indication(obs[3]),
        .general_error_flag(obs[2]), .bus_error_flag(obs[1]), .remote_io_error_flag(obs[0]));
    task automatic drive(input logic [7:0] l, s, d, f);
        @(posedge sys_clk);
        link_up  <= l;
        io_short <= s;
        dup_same <= d;
        dup_diff <= f;
        repeat (6) @(posedge sys_clk);
    endtask : drive
    task automatic pulse_clear();
        flags_clear <= 1'b1;
        @(posedge sys_clk);
        flags_clear <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse_clear
    task automatic clear_all();
        drive(8'h0F, 8'h00, 8'h00, 8'h00);
        pulse_clear();
    endtask : clear_all
    task automatic partial_cut();
        drive(8'h0E, 8'h00, 8'h00, 8'h00);
        `CHK(obs, 6'b111110)
        `CHK(outs, 8'h0E)
        `CHK(warn, 1'b0)
        // Clear while the cut stands is refused
        pulse_clear();
        `CHK(obs, 6'b111110)
        drive(8'h0F, 8'h00, 8'h00, 8'h00);
        `CHK(obs, 6'b000110)
        clear_all();
        `CHK(obs, 6'b000000)
    endtask : partial_cut
    task automatic lost_cases();
        drive(8'h00, 8'h00, 8'h00, 8'h00);
        `CHK(obs, 6'b010110)
        clear_all();
        drive(8'h0C, 8'h00, 8'h00, 8'h00);
        `CHK(obs, 6'b010110)
        clear_all();
    endtask : lost_cases
    task automatic io_and_dup();
        drive(8'h0F, 8'h01, 8'h00, 8'h00);
        `CHK(obs, 6'b001101)
        `CHK(warn, 1'b1)
        clear_all();
        drive(8'h0F, 8'h00, 8'h03, 8'h00);
        `CHK(obs, 6'b000000)
        drive(8'h0F, 8'h00, 8'h03, 8'h03);
        `CHK(obs & 6'b001111, 6'b001110)
        clear_all();
    endtask : io_and_dup
    task automatic config_cases();
        cfg <= 8'h07;
        drive(8'h04, 8'h00, 8'h00, 8'h00);
        `CHK(obs, 6'b010110)
        clear_all();
        // Three of eight lost is only a partial cut
        cfg <= 8'hFF;
        drive(8'hF8, 8'h00, 8'h00, 8'h00);
        `CHK(obs, 6'b111110)
        cfg <= 8'h0F;
        clear_all();
    endtask : config_cases
    task automatic reset_mid();
        drive(8'h0E, 8'h00, 8'h00, 8'h00);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK({obs, warn}, 7'b0000000)
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK(obs, 6'b111110)
        clear_all();
    endtask : reset_mid
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK(obs, 6'b000000)
        partial_cut();
        lost_cases();
        io_and_dup();
        config_cases();
        reset_mid();
        wrap_up();
    end
    // Whole run needs about 200 cycles
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end
endmodule : fieldbus_error_reaction_tb
`default_nettype wire
